// >>> core/bkr_pkg.sv
package bkr_pkg;
    // Width of cycle count settings
    localparam int CNT_W = 16;
    // Fixed flag pulse length in power cycles
    localparam logic [CNT_W-1:0] FLAG_HOLD_CYC = 16'h003c;
    // Count reset value
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    // Count step
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
endpackage : bkr_pkg

// >>> core/bkr_sync.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser for a bus of pin inputs
module bkr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            meta_r <= '0;
            o_q <= '0;
        end
        else
        begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end
endmodule : bkr_sync

// >>> core/bkr_timers.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Close failure timer starts with close output.
// - Close held until timeout or breaker aux.
// - Aux de-energized means breaker is open.
// - Failure and hold times set in cycles.
// - Close failure flag pulses exactly 60 cycles.
// - Close output drops when close flag rises.
// - Close from operator command or direct close.
// - Mapped output follows flag, 60 cycles.
// - Trip asserts at once on trip equation.
// - Trip failure timer starts with trip output.
// - Trip held until hold timer and equation clear.
// - Release also needs pickups dropped or reset.
// - Trip failure timeout raises flag, and output four when mapped to trip.
////////////////////////////////////////////////////////////////////////////////
module bkr_timers
    import bkr_pkg::*;
#(
    parameter int SYNC_W = 6
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Power-system cycle tick, one clock wide, same domain
    input wire logic i_cycle_tick,
    // Settings in power cycles
    input wire logic [bkr_pkg::CNT_W-1:0] i_close_fail_time_setting,
    input wire logic [bkr_pkg::CNT_W-1:0] i_trip_fail_time_setting,
    input wire logic [bkr_pkg::CNT_W-1:0] i_trip_hold_time_setting,
    // Operator commands, same domain, one-cycle pulses
    input wire logic i_close_cmd,
    input wire logic i_target_reset,
    // Element states, same domain
    input wire logic i_trip_equation,
    input wire logic i_any_pickup,
    input wire logic i_fault_current,
    // Contact inputs from pins
    input wire logic i_direct_close_input,
    input wire logic i_breaker_aux_input,
    // Map of output contact four: 0 close failure, 1 trip failure
    input wire logic i_prog4_sel_trip,
    // Outputs
    output logic o_close,
    output logic o_trip,
    output logic o_close_fail_flag,
    output logic o_trip_fail_flag,
    output logic o_prog_output_4,
    output logic o_breaker_open
);
    ////////////////////////////////////////////////////////////////////////////
    // Elaboration check on SYNC_W, which does not set the fixed two-stage synchroniser depth
    // A single stage would let a metastable pin value reach the timers
    generate
        if (SYNC_W < 2)
        begin : g_bad_sync
            $error("bkr_timers: SYNC_W too small");
        end
    endgenerate

    typedef struct packed {
        logic rst_m;
        logic rst_s;
        logic close;
        logic trip;
        logic cf;
        logic tf;
        logic prog4;
        logic open;
        logic [CNT_W-1:0] cf_cnt;
        logic [CNT_W-1:0] cf_pulse;
        logic [CNT_W-1:0] tf_cnt;
        logic [CNT_W-1:0] tf_drop;
        logic [CNT_W-1:0] hold_cnt;
    } bkr_state_t;

    bkr_state_t st_r;
    bkr_state_t st_nxt;
    logic [1:0] pins_s;
    logic dc_s;
    logic aux_s;
    logic nrst_int;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    // Both contact inputs come from field wiring with no relation to i_clk
    // Two stages add two clocks of latency, far below one power cycle
    bkr_sync #(.W(2)) u_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_d({i_direct_close_input, i_breaker_aux_input}),
        .o_q(pins_s)
    );
    assign dc_s = pins_s[1];
    assign aux_s = pins_s[0];
    assign nrst_int = st_r.rst_s;

    // Saturating cycle counter step
    // Saturation keeps a long hold from wrapping and looking unexpired again
    function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v);
        inc_sat = (v == {CNT_W{1'b1}}) ? v : v + CNT_ONE;
    endfunction : inc_sat

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rst_m = 1'b1;
        st_nxt.rst_s = st_r.rst_m;
        st_nxt.open = ~aux_s;
        // Close logic
        // Aux closing wins over timer expiry in the same cycle
        // A new close is refused while the failure pulse is up
        // A closed breaker refuses a close, so no second coil pulse
        if (st_r.close)
        begin
            if (aux_s)
            begin
                st_nxt.close = 1'b0;
                st_nxt.cf_cnt = CNT_ZERO;
            end
            else if (i_cycle_tick)
            begin
                if (inc_sat(st_r.cf_cnt) >= i_close_fail_time_setting)
                begin
                    st_nxt.close = 1'b0;
                    st_nxt.cf = 1'b1;
                    st_nxt.cf_pulse = CNT_ZERO;
                    st_nxt.cf_cnt = CNT_ZERO;
                end
                else
                    st_nxt.cf_cnt = inc_sat(st_r.cf_cnt);
            end
        end
        else if ((i_close_cmd || dc_s) && !aux_s && !st_r.cf)
        begin
            st_nxt.close = 1'b1;
            st_nxt.cf_cnt = CNT_ZERO;
        end
        // Close failure pulse
        // Counts ticks from the rise, so the width is a whole number of cycles
        if (st_r.cf && i_cycle_tick)
        begin
            st_nxt.cf_pulse = inc_sat(st_r.cf_pulse);
            if (inc_sat(st_r.cf_pulse) >= FLAG_HOLD_CYC)
                st_nxt.cf = 1'b0;
        end
        // Trip logic
        // Trip sets in the cycle after the equation, with no tick needed
        // Hold and failure counters both start from the trip rise
        // Release waits for hold expiry, equation clear and pickups or reset
        if (!st_r.trip)
        begin
            if (i_trip_equation)
            begin
                st_nxt.trip = 1'b1;
                st_nxt.hold_cnt = CNT_ZERO;
                st_nxt.tf_cnt = CNT_ZERO;
            end
        end
        else
        begin
            if (i_cycle_tick)
            begin
                st_nxt.hold_cnt = inc_sat(st_r.hold_cnt);
                st_nxt.tf_cnt = inc_sat(st_r.tf_cnt);
                if (!st_r.tf && inc_sat(st_r.tf_cnt) >= i_trip_fail_time_setting)
                begin
                    st_nxt.tf = 1'b1;
                    st_nxt.tf_drop = CNT_ZERO;
                end
            end
            if (st_r.hold_cnt >= i_trip_hold_time_setting && !i_trip_equation
                && (!i_any_pickup || i_target_reset))
                st_nxt.trip = 1'b0;
        end
        // Trip failure drop-out after current removed
        // Returning current restarts the drop-out count from zero
        if (st_r.tf)
        begin
            if (i_fault_current)
                st_nxt.tf_drop = CNT_ZERO;
            else if (i_cycle_tick)
            begin
                st_nxt.tf_drop = inc_sat(st_r.tf_drop);
                if (inc_sat(st_r.tf_drop) >= FLAG_HOLD_CYC
                    && !(st_nxt.tf && !st_r.tf))
                    st_nxt.tf = 1'b0;
            end
        end
        // Output contact four follows its flag
        st_nxt.prog4 = i_prog4_sel_trip ? st_nxt.tf : st_nxt.cf;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register, internal reset loads constants except rst_s, which takes rst_m
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            st_r <= '{default: '0, open: 1'b1};
        else if (!nrst_int)
        begin
            st_r <= '{default: '0, open: 1'b1};
            st_r.rst_m <= 1'b1;
            st_r.rst_s <= st_r.rst_m;
        end
        else
            st_r <= st_nxt;
    end

    // Outputs straight from flip-flops
    // No logic between the state register and the pins
    assign o_close = st_r.close;
    assign o_trip = st_r.trip;
    assign o_close_fail_flag = st_r.cf;
    assign o_trip_fail_flag = st_r.tf;
    assign o_prog_output_4 = st_r.prog4;
    assign o_breaker_open = st_r.open;
endmodule : bkr_timers

// >>> test/bkr_timers_sva.sv
`timescale 1ns/1ps
module bkr_timers_sva(
// Watched ports
input wire logic i_clk, i_nrst, i_cycle_tick, i_target_reset, i_trip_equation,
input wire logic i_any_pickup, i_breaker_aux_input, i_prog4_sel_trip, o_close,
input wire logic o_trip, o_close_fail_flag, o_trip_fail_flag, o_prog_output_4,
input wire logic o_breaker_open
);
default clocking @(posedge i_clk); endclocking
default disable iff (!i_nrst);
logic [7:0] cf_n;
// Ticks while close failure flag is up
always_ff @(posedge i_clk or negedge i_nrst)
begin
    if (!i_nrst)
        cf_n <= 8'h00;
    else
        cf_n <= o_close_fail_flag ? cf_n + {7'h00, i_cycle_tick} : 8'h00;
end
a_close_flag_swap: assert property ($rose(o_close_fail_flag) |-> $fell(o_close))
    else $error("close kept");
a_flag_width: assert property ($fell(o_close_fail_flag) |-> cf_n == 8'h3c)
    else $error("cf width");
a_flag_to_out: assert property ($rose(o_close_fail_flag) && !i_prog4_sel_trip
    |-> ##[0:1] o_prog_output_4) else $error("out4 idle");
a_trip_at_once: assert property (i_trip_equation && !o_trip |=> o_trip)
    else $error("trip late");
a_trip_hold: assert property (o_trip && i_trip_equation |=> o_trip)
    else $error("trip dropped");
a_trip_release: assert property ($fell(o_trip) |-> !$past(i_trip_equation)
    && (!$past(i_any_pickup) || $past(i_target_reset))) else $error("trip freed");
a_tf_after_trip: assert property ($rose(o_trip_fail_flag) |-> $past(o_trip))
    else $error("tf no trip");
a_aux_closed: assert property ($rose(i_breaker_aux_input) |-> ##[1:4] !o_breaker_open)
    else $error("open kept");
endmodule: bkr_timers_sva
bind bkr_timers bkr_timers_sva u_bkr_timers_sva(.*);

// >>> test/bkr_breaker_model.sv
`timescale 1ns/1ps
// Breaker: aux closes 2 or 9 clocks after close when working, opens on trip
module bkr_breaker_model(
input wire logic i_clk, i_close, i_trip, i_works, i_slow,
output logic o_aux = 1'h0
);
logic [7:0] sr = 8'h00;
// Mechanism travel
always @(posedge i_clk)
begin
    sr <= {sr[6:0], i_close & i_works};
    if (i_trip) o_aux <= 1'h0;
    else if (i_slow ? sr[7] : sr[0]) o_aux <= 1'h1;
end
endmodule: bkr_breaker_model

// >>> test/bkr_timers_tb.sv
`timescale 1ns/1ps
module bkr_timers_tb;
logic clk = 0, nrst = 0, cmd = 0, trs = 0, eq = 0, pk = 0, fc = 0, dc = 0, sel = 0, wk = 0;
logic cl, tr, cf, tf, p4, op, aux;
logic [1:0] tc = 2'h0;
logic [15:0] t;
int n_fail = 0, comparisons = 0, k;
// Clock, and a power cycle tick every fourth clock
initial forever #50 clk = ~clk;
always @(posedge clk) tc <= tc + 2'h1;
bkr_timers u_bkr_timers(.i_clk(clk), .i_nrst(nrst), .i_cycle_tick(tc == 2'h3),
    .i_close_fail_time_setting(16'h0005), .i_trip_fail_time_setting(16'h0004),
    .i_trip_hold_time_setting(16'h0002), .i_close_cmd(cmd), .i_target_reset(trs),
    .i_trip_equation(eq), .i_any_pickup(pk), .i_fault_current(fc),
    .i_direct_close_input(dc), .i_breaker_aux_input(aux), .i_prog4_sel_trip(sel),
    .o_close(cl), .o_trip(tr), .o_close_fail_flag(cf), .o_trip_fail_flag(tf),
    .o_prog_output_4(p4), .o_breaker_open(op));
bkr_breaker_model u_bkr_breaker_model(.i_clk(clk), .i_close(cl), .i_trip(tr),
    .i_works(wk), .i_slow(sel), .o_aux(aux));
// Compare and count
task chk(string n, logic [15:0] e, s);
    comparisons++;
    if (s !== e)
    begin
        n_fail++;
        $display("[FAIL] %s exp %0h got %0h", n, e, s);
    end
endtask: chk
// Bounded wait for a level, counting ticks on the way
task automatic tk(ref logic s, input logic v);
    t = 16'h0000;
    for (k = 0; k < 999; k++)
    begin
        #1;
        if (s === v) break;
        @(posedge clk);
        t += {15'h0000, tc == 2'h3};
    end
    if (k == 999)
    begin
        n_fail++;
        $display("[FAIL] wait exp %0h got %0h", v, s);
    end
endtask: tk
task t_cfail;
    @(posedge clk) cmd <= 1'h1;
    @(posedge clk) cmd <= 1'h0;
    tk(cl, 1'h1);
    tk(cf, 1'h1);
    chk("cf at", 16'h0005, t);
    chk("close", 16'h0000, cl);
    chk("out4 on", 16'h0001, p4);
    tk(cf, 1'h0);
    chk("cf len", 16'h003c, t);
    @(posedge clk) #1 chk("out4", 16'h0000, p4);
    $display("cfail end");
endtask: t_cfail
task t_cok;
    @(posedge clk);
    wk <= 1'h1;
    sel <= 1'h1;
    dc <= 1'h1;
    tk(cl, 1'h1);
    tk(cl, 1'h0);
    repeat (60) @(posedge clk);
    dc <= 1'h0;
    #1 chk("open", 16'h0000, op);
    chk("cf quiet", 16'h0000, cf);
    $display("cok end");
endtask: t_cok
task t_trip;
    @(posedge clk);
    eq <= 1'h1;
    pk <= 1'h1;
    fc <= 1'h1;
    @(posedge clk) #1 chk("trip", 16'h0001, tr);
    tk(tf, 1'h1);
    chk("tf at", 16'h0004, t);
    @(posedge clk) eq <= 1'h0;
    repeat (40) @(posedge clk);
    #1 chk("latched", 16'h0001, tr);
    chk("out4 tf", 16'h0001, p4);
    @(posedge clk) trs <= 1'h1;
    @(posedge clk) trs <= 1'h0;
    tk(tr, 1'h0);
    chk("freed", 16'h0000, tr);
    @(posedge clk) fc <= 1'h0;
    tk(tf, 1'h0);
    chk("tf len", 16'h003c, t);
    $display("trip end");
endtask: t_trip
task results;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask: results
// Reset, then the scenarios
initial
begin
    repeat (16) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    #1 chk("rst open", 16'h0001, op);
    t_cfail;
    t_cok;
    t_trip;
    results;
end
// Hang guard
initial
begin
    #2000000;
    n_fail++;
    results;
end
endmodule: bkr_timers_tb
